// *** dv/port_pad_function_mux_assertions.sv ***
// ------------------------------------------------
// pad mux port checker
// ------------------------------------------------
module pad_mux_checker
	import pad_mux_pkg::*;
#(
	parameter int PADS = 16
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [pad_mux_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire pad_mux_pkg::func_out_t [PADS-1:0] func_out,
	input wire logic [PADS-1:0] special_module_en,
	input wire logic [PADS-1:0] pad_in,
	input wire logic [PADS-1:0] pad_out,
	input wire logic [PADS-1:0] pad_oe_n,
	input wire logic [PADS-1:0] pad_pull_en,
	input wire logic [PADS-1:0] pad_analog_en,
	input wire logic [PADS-1:0] periph_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// pad side relations and bus timing
	property p_spec; (special_module_en & ~pad_analog_en) == '0; endproperty
	a_spec: assert property (p_spec) else $error("special enable lost");
	property p_pin; (periph_in & ~pad_in) == '0; endproperty
	a_pin: assert property (p_pin) else $error("input not from pad");
	property p_rsv;
		pad_out[15:14] == 2'h0 && periph_in[15:14] == 2'h0 && pad_oe_n[15:14] == 2'h3;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved pad active");
	property p_rsvrd;
		avs_read && !avs_waitrequest && avs_address[7:3] == 5'h07 |-> avs_readdata == '0;
	endproperty
	a_rsvrd: assert property (p_rsvrd) else $error("reserved read not zero");
	property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("read answer late");
	property p_hold; !(avs_read || avs_write) |=> $stable(avs_readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rpull; $rose(reset_n) |-> pad_pull_en[5:0] == 6'h0b; endproperty
	a_rpull: assert property (p_rpull) else $error("reset pull wrong");
	property p_rtdo; $rose(reset_n) |-> !pad_oe_n[2] && pad_out[2] == func_out[2].out[1];
	endproperty
	a_rtdo: assert property (p_rtdo) else $error("test out pad wrong");
	c_wr: cover property (avs_write && !avs_waitrequest);
	c_rd: cover property (avs_read && !avs_waitrequest);
	c_sp: cover property (|special_module_en);
endmodule : pad_mux_checker

bind port_pad_function_mux pad_mux_checker #(.PADS(PADS)) chk_i (.clk(clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .func_out(func_out),
	.special_module_en(special_module_en), .pad_in(pad_in), .pad_out(pad_out),
	.pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en), .pad_analog_en(pad_analog_en),
	.periph_in(periph_in));

// *** dv/port_pad_function_mux_tb_top.sv ***
module port_pad_function_mux_tb_top
	import pad_mux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, serial_flash_mode = 0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
	logic avs_waitrequest;
	logic [3:0] avs_byteenable = 4'hf;
	logic [15:0] special_module_en = 16'h0000, pad_in = 16'hc040;
	logic [15:0] pad_out, pad_oe_n, pad_pull_en, pad_analog_en, periph_in;
	logic [3:0] sel_periph_in;
	func_out_t [15:0] func_out = {16{8'h95}};
	// row: flash mode, pad 6 config, then expected out, oe_n, periph_in, analog, pull
	logic [11:0] rows [11] = '{12'h010, 12'h028, 12'h040, 12'h078, 12'h858, 12'h094,
		12'h0fc, 12'h112, 12'h220, 12'h479, 12'h878};
	int err_count = 0, total_checks = 0;
	// clock
	initial forever #5 clk = ~clk;
	port_pad_function_mux uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.func_out(func_out), .special_module_en(special_module_en),
		.serial_flash_mode(serial_flash_mode), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en), .pad_analog_en(pad_analog_en),
		.periph_in(periph_in), .sel_periph_in(sel_periph_in));
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest samples low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// watchdog
	initial
	begin
		#20000;
		err_count++;
		complete_run;
	end
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		bus(0, 8'h00, '0); chk("cfg0", q, 32'h0000_0025);
		bus(0, 8'h08, '0); chk("cfg2", q, 32'h0000_0011);
		bus(0, 8'h0c, '0); chk("cfg3", q, 32'h0000_0025);
		bus(0, 8'h10, '0); chk("cfg4", q, 32'h0000_0004);
		bus(0, 8'h1c, '0); chk("cfg7", q, 32'h0000_0000);
		$display("reset values done");
		for (int k = 0; k < 11; k++)
		begin
			@(posedge clk);
			serial_flash_mode <= rows[k][11];
			bus(1, 8'h18, {26'h000_0000, rows[k][10:5]});
			@(negedge clk);
			chk("pad_out", pad_out[6], rows[k][4]);
			chk("pad_oe_n", pad_oe_n[6], rows[k][3]);
			chk("periph_in", periph_in[6], rows[k][2]);
			chk("analog", pad_analog_en[6], rows[k][1]);
			chk("pull", pad_pull_en[6], rows[k][0]);
		end
		$display("function rows done");
		bus(1, 8'h18, 32'h0000_0004);
		bus(1, 8'h40, 32'h0000_0006);
		@(negedge clk);
		chk("sel", sel_periph_in[0], 1'h1);
		bus(0, 8'h50, '0); chk("pad levels", q, 32'h0000_0040);
		pad_in <= 16'h0000;
		@(negedge clk);
		chk("sel", sel_periph_in[0], 1'h0);
		bus(0, 8'h40, '0); chk("src0", q, 32'h0000_0006);
		avs_byteenable <= 4'he;
		bus(1, 8'h18, 32'h0000_003f);
		avs_byteenable <= 4'hf;
		bus(0, 8'h18, '0); chk("lane0 off", q, 32'h0000_0004);
		bus(1, 8'h38, 32'h0000_003f);
		bus(0, 8'h38, '0); chk("rsv", q, 32'h0000_0000);
		chk("rsv pad", pad_out[14], 1'h0);
		chk("rsv drive", pad_oe_n[14], 1'h1);
		chk("no special", pad_analog_en[7], 1'h0);
		special_module_en <= 16'h0080;
		@(negedge clk);
		chk("special", pad_analog_en[7], 1'h1);
		bus(0, 8'h54, '0); chk("special rd", q, 32'h0000_0080);
		$display("select and special done");
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		bus(0, 8'h18, '0); chk("cfg6", q, 32'h0000_0000);
		bus(0, 8'h40, '0); chk("src0", q, 32'h0000_0000);
		$display("second reset done");
		complete_run;
	end
endmodule : port_pad_function_mux_tb_top

// *** verilog/pad_cell_mux.sv ***
// one pad: selects output function and gates the input path
module pad_cell_mux
	import pad_mux_pkg::*;
(
	input wire pad_mux_pkg::pad_cfg_t cfg,
	input wire pad_mux_pkg::func_out_t funcs,
	input wire logic special_active,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	output logic periph_in,
	output logic analog_en
);

	// ----------------------------------------------------------------
	// output routing
	// ----------------------------------------------------------------
	always_comb
	begin
		pad_out = funcs.out[cfg.alt_function_select]; // see [RULE_01]
		pad_oe_n = ~(cfg.out_en | funcs.oe[cfg.alt_function_select]);
		// digital input does not care about alt select
		periph_in = cfg.input_buffer_enable & pad_in; // see [RULE_02]
		// special path runs beside the digital one, undisturbed by it
		analog_en = cfg.analog_en | special_active; // see [RULE_03] see [RULE_04]
	end

endmodule : pad_cell_mux

// *** verilog/pad_mux_pkg.sv ***
package pad_mux_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_PADS = 16;
	localparam int NUM_SEL_INPUTS = 4;
	localparam int ADDR_W = 8;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] PAD_CFG_BASE = 8'h00;
	localparam logic [7:0] SRC_SEL_BASE = 8'h40;
	localparam logic [7:0] PAD_IN_ADDR = 8'h50;
	localparam logic [7:0] SPECIAL_ADDR = 8'h54;

	// pad positions: debug pads at 0..3, display syncs at 4..5, reserved at 14..15
	localparam int DBG_CLK_PAD = 0;
	localparam int DBG_DIN_PAD = 1;
	localparam int DBG_DOUT_PAD = 2;
	localparam int DBG_MODE_PAD = 3;
	localparam int VSYNC_PAD = 4;
	localparam int HSYNC_PAD = 5;
	localparam logic [15:0] RESERVED_MASK = 16'hc000;

	// ----------------------------------------------------------------
	// pad configuration fields
	// ----------------------------------------------------------------
	localparam int ALT_LSB = 0;
	localparam int INBUF_BIT = 2;
	localparam int ANALOG_BIT = 3;
	localparam int OBE_BIT = 4;
	localparam int PULL_BIT = 5;
	localparam logic [1:0] ALT_OPT0 = 2'h0;
	localparam logic [1:0] ALT_OPT1 = 2'h1;
	localparam logic [1:0] ALT_OPT2 = 2'h2;
	localparam logic [1:0] ALT_OPT3 = 2'h3;
	localparam logic [5:0] CFG_RST_NONE = 6'h00;
	localparam logic [5:0] CFG_RST_IN_PU = 6'h25;
	localparam logic [5:0] CFG_RST_OUT = 6'h11;
	localparam logic [5:0] CFG_RST_IN = 6'h04;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef struct packed {
		logic pull_en;
		logic out_en;
		logic analog_en;
		logic input_buffer_enable;
		logic [1:0] alt_function_select;
	} pad_cfg_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} func_out_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACK = 3'b010,
		BUS_DONE = 3'b100
	} bus_state_t;

endpackage : pad_mux_pkg

// *** verilog/port_pad_function_mux.sv ***
// Function
// [RULE_01] two-bit alt field picks output option
// [RULE_02] peripheral input gated only by buffer enable
// [RULE_03] special functions independent of digital selection
// [RULE_04] analog bit or owner module enables special
// [RULE_05] source select registers steer peripheral inputs
// [RULE_06] debug pads start as test port
// [RULE_07] pads reset with documented direction and pull
// [RULE_08] flash pads follow controller serial mode
// [RULE_09] reserved positions: no register, read zero; the special read at SPECIAL_ADDR still returns special_module_en bits 14..15
// [RULE_10] default reset: option zero, buffer off
module port_pad_function_mux
	import pad_mux_pkg::*;
#(
	parameter int PADS = pad_mux_pkg::NUM_PADS,
	parameter int SEL_INPUTS = pad_mux_pkg::NUM_SEL_INPUTS
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [pad_mux_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pad_mux_pkg::func_out_t [PADS-1:0] func_out,
	input wire logic [PADS-1:0] special_module_en,
	input wire logic serial_flash_mode,
	input wire logic [PADS-1:0] pad_in,
	output logic [PADS-1:0] pad_out,
	output logic [PADS-1:0] pad_oe_n,
	output logic [PADS-1:0] pad_pull_en,
	output logic [PADS-1:0] pad_analog_en,
	output logic [PADS-1:0] periph_in,
	output logic [SEL_INPUTS-1:0] sel_periph_in
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pad_cfg_t [PADS-1:0] cfg_r, cfg_nxt;
	logic [3:0] src_sel_r [SEL_INPUTS], src_sel_nxt [SEL_INPUTS];
	bus_state_t bus_r, bus_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [PADS-1:0] pin_mux_in;
	logic [PADS-1:0] cell_oe_n;
	logic wr_commit;
	func_out_t [PADS-1:0] eff_func;

	// reset value of one pad's configuration
	function automatic pad_cfg_t reset_cfg(input int idx);
		if (idx == DBG_CLK_PAD || idx == DBG_DIN_PAD || idx == DBG_MODE_PAD)
			return pad_cfg_t'(CFG_RST_IN_PU); // see [RULE_06] see [RULE_07]
		else if (idx == DBG_DOUT_PAD)
			return pad_cfg_t'(CFG_RST_OUT); // see [RULE_06] see [RULE_07]
		else if (idx == VSYNC_PAD || idx == HSYNC_PAD)
			return pad_cfg_t'(CFG_RST_IN); // see [RULE_07]
		else
			return pad_cfg_t'(CFG_RST_NONE); // see [RULE_10]
	endfunction : reset_cfg

	// reserved position check
	function automatic logic is_reserved(input int idx);
		return RESERVED_MASK[idx[3:0]];
	endfunction : is_reserved

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// pad configuration word idx; reserved positions have no register
	function automatic logic cfg_hit(input logic [ADDR_W-1:0] addr, input int idx);
		return (addr == PAD_CFG_BASE + 8'(4 * idx)) && !is_reserved(idx);
	endfunction : cfg_hit

	// source select word idx
	function automatic logic sel_hit(input logic [ADDR_W-1:0] addr, input int idx);
		return addr == SRC_SEL_BASE + 8'(4 * idx);
	endfunction : sel_hit

	// ----------------------------------------------------------------
	// flash mode: option 2 takes the option 3 functions on every pad, option 3 kept
	// ----------------------------------------------------------------
	always_comb
	begin
		eff_func = func_out;
		// only option 2 is remapped in flash mode; option 3 keeps its own functions
		if (serial_flash_mode)
		begin
			for (int i = 0; i < PADS; i++)
			begin
				eff_func[i].out[ALT_OPT2] = func_out[i].out[ALT_OPT3]; // see [RULE_08]
				eff_func[i].oe[ALT_OPT2] = func_out[i].oe[ALT_OPT3];
			end
		end
	end

	// ----------------------------------------------------------------
	// pad cells
	// ----------------------------------------------------------------
	for (genvar g = 0; g < PADS; g++)
	begin : g_pad
		pad_cell_mux u_cell (
			.cfg(cfg_r[g]),
			.funcs(eff_func[g]),
			.special_active(special_module_en[g]),
			.pad_in(pad_in[g]),
			.pad_out(pin_mux_in[g]),
			.pad_oe_n(cell_oe_n[g]),
			.periph_in(periph_in[g]),
			.analog_en(pad_analog_en[g])
		);
		assign pad_pull_en[g] = cfg_r[g].pull_en;
	end

	// reserved positions have no pad: data held low and driver kept off
	always_comb
	begin
		for (int i = 0; i < PADS; i++)
		begin
			pad_out[i] = pin_mux_in[i] & ~RESERVED_MASK[i]; // see [RULE_09]
			pad_oe_n[i] = cell_oe_n[i] | RESERVED_MASK[i]; // see [RULE_09]
		end
	end

	// ----------------------------------------------------------------
	// selectable peripheral inputs
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int s = 0; s < SEL_INPUTS; s++)
			sel_periph_in[s] = periph_in[src_sel_r[s]]; // see [RULE_05]
	end

	// ----------------------------------------------------------------
	// register bus: two wait cycles, then answer
	// ----------------------------------------------------------------
	always_comb
	begin
		cfg_nxt = cfg_r;
		src_sel_nxt = src_sel_r;
		bus_nxt = bus_r;
		rdata_nxt = rdata_r;
		case (bus_r)
			BUS_IDLE:
			begin
				if (avs_read || avs_write)
					bus_nxt = BUS_ACK;
			end
			BUS_ACK:
			begin
				bus_nxt = BUS_DONE;
				// read data is captured here and stands through the answer cycle
				rdata_nxt = UNMAPPED_DATA;
				for (int i = 0; i < PADS; i++)
				begin
					if (cfg_hit(avs_address, i))
					begin
						rdata_nxt = {26'h000_0000, cfg_r[i]}; // see [RULE_09]
					end
				end
				for (int s = 0; s < SEL_INPUTS; s++)
				begin
					if (sel_hit(avs_address, s))
					begin
						rdata_nxt = {28'h000_0000, src_sel_r[s]};
					end
				end
				if (avs_address == PAD_IN_ADDR)
					rdata_nxt = {16'h0000, pad_in & ~RESERVED_MASK};
				if (avs_address == SPECIAL_ADDR)
					rdata_nxt = {16'h0000, pad_analog_en};
			end
			BUS_DONE:
			begin
				bus_nxt = BUS_IDLE;
				// writes land only at the edge where waitrequest is seen low
				for (int i = 0; i < PADS; i++)
				begin
					if (wr_commit && cfg_hit(avs_address, i))
						cfg_nxt[i] = pad_cfg_t'(avs_writedata[5:0]); // see [RULE_09]
				end
				for (int s = 0; s < SEL_INPUTS; s++)
				begin
					if (wr_commit && sel_hit(avs_address, s))
						src_sel_nxt[s] = avs_writedata[3:0]; // see [RULE_05]
				end
			end
			default:
				bus_nxt = BUS_IDLE;
		endcase
	end

	// register stage
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			// debug and sync pads start in their fixed roles
			for (int i = 0; i < PADS; i++)
				cfg_r[i] <= reset_cfg(i);
			for (int s = 0; s < SEL_INPUTS; s++)
				src_sel_r[s] <= 4'h0;
			bus_r <= BUS_IDLE;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			src_sel_r <= src_sel_nxt;
			bus_r <= bus_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// a write commits only in the answer cycle, with lane 0 enabled
	assign wr_commit = (bus_r == BUS_DONE) && avs_write && avs_byteenable[0];

	// answer the cycle after the access is decoded
	assign avs_waitrequest = (avs_read || avs_write) && (bus_r != BUS_DONE);
	assign avs_readdata = rdata_r;

endmodule : port_pad_function_mux
